// ---- dso_status_out.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Ready flag is on whenever the drive can operate, including while running.
// - Rotating flag turns on once output frequency reaches the starting level.
// - Outside a restart sequence, rotating flag stays off while stopped or under DC injection braking.
// - Codes 11/111 select ready flag, codes 0/100 select rotating flag.
// - Restarting sets ready and rotating; coasting with start on keeps ready only.
// - Coasting without start drops ready during supply loss or undervoltage.
// - After reset the rotating flag drives the rotating terminal, positive logic.
// - Any protective trip sets the trip fault flag.
// - Trip flag drives relay contact by default; codes 99/199 route it.
// - Hard-fault flag is set by the seven listed internal faults or by an earth-fault acceleration overcurrent trip.
// - Codes 91/191 route the hard-fault flag to a terminal.
// - Earth fault reported as acceleration overcurrent still sets hard-fault flag.
// - At-speed flag on within band percent of set frequency; band 0-100, reset 10.
// - Codes 1/101 route the at-speed flag to a terminal.
// - Threshold flag on at or above forward level; 0-400 Hz, reset 6 Hz.
// - Reverse level 9999 means forward level both ways, else used in reverse.
// - Threshold flag drives its own terminal by default; codes 4/104 route it.
// - At-speed and threshold flags are forced off during DC injection braking.
// - Comparisons use output frequency before slip compensation.
// - Codes 0-99 conduct while flag active; codes 100-199 stop conducting.
// - One flag may be selected on several terminals at once.
module dso_status_out
  import dso_pkg::*;
#(
  parameter int unsigned FREQ_BITS = FREQ_W
)(
  input wire logic i_clock,
  input wire logic i_srst,
  // Register port
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  output logic [DATA_W-1:0] o_reg_rdata,
  // Drive controller state
  input wire logic [FREQ_W-1:0] i_out_freq_preslip,
  input wire logic [FREQ_W-1:0] i_set_freq,
  input wire logic i_reverse,
  input wire logic i_able_to_run,
  input wire logic i_stopped,
  input wire logic i_dc_brake,
  input wire logic i_output_shutoff_in,
  input wire logic i_trip,
  input wire logic [NUM_FLT-1:0] i_fault_src,
  input wire logic i_accel_overcurrent_trip,
  input wire logic i_earth_fault_cause,
  input wire logic i_restart_seq,
  input wire logic i_restarting,
  input wire logic i_start_cmd,
  input wire logic i_supply_ok,
  // Status terminals: rotating, threshold, relay contact
  output logic [NUM_TERMS-1:0] o_terminal,
  output logic [NUM_FLAGS-1:0] o_flags
);

  // ==========================================================
  // Elaboration checks
  if (FREQ_BITS != FREQ_W) begin : g_bad_width
    $error("dso_status_out: FREQ_BITS must equal the package frequency width");
  end
  // Selector addressing and the read mux are laid out for these sizes
  if (NUM_TERMS != 3) begin : g_bad_terms
    $error("dso_status_out: three terminal selectors are mapped at indices 4 to 6");
  end
  if (NUM_FLAGS != 6) begin : g_bad_flags
    $error("dso_status_out: the flag vector holds exactly six flags");
  end
  if (DATA_W < 16) begin : g_bad_data
    $error("dso_status_out: settings registers need a 16-bit data path");
  end
  if (ADDR_W < 4) begin : g_bad_addr
    $error("dso_status_out: register indices need four address bits");
  end

  // ==========================================================
  // Register file
  logic [15:0] start_freq_q, start_freq_d;
  logic [15:0] band_q, band_d;
  logic [15:0] fwd_level_q, fwd_level_d;
  logic [15:0] rev_level_q, rev_level_d;
  logic [15:0] term_sel_q [NUM_TERMS];
  logic [15:0] term_sel_d [NUM_TERMS];
  logic wr_err_q, wr_err_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  function automatic logic freq_ok(input logic [15:0] v);
    freq_ok = (v <= MAX_FREQ);
  endfunction : freq_ok

  function automatic logic code_ok(input logic [15:0] v);
    code_ok = (v <= CODE_MAX) || (v == CODE_NONE);
  endfunction : code_ok

  logic wr_reject;

  always_comb begin
    start_freq_d = start_freq_q;
    band_d = band_q;
    fwd_level_d = fwd_level_q;
    rev_level_d = rev_level_q;
    term_sel_d = term_sel_q;
    wr_reject = 1'b0;
    if (i_reg_write) begin
      unique case (i_reg_addr)
        REG_START_FREQ: begin
          if (freq_ok(i_reg_wdata)) begin
            start_freq_d = i_reg_wdata;
          end else begin
            wr_reject = 1'b1;
          end
        end
        REG_AT_SPEED_BAND: begin
          if (i_reg_wdata <= MAX_BAND) begin
            band_d = i_reg_wdata;
          end else begin
            wr_reject = 1'b1;
          end
        end
        REG_FWD_DETECT: begin
          if (freq_ok(i_reg_wdata)) begin
            fwd_level_d = i_reg_wdata;
          end else begin
            wr_reject = 1'b1;
          end
        end
        REG_REV_DETECT: begin
          if (freq_ok(i_reg_wdata) || (i_reg_wdata == REV_SAME_AS_FWD)) begin
            rev_level_d = i_reg_wdata;
          end else begin
            wr_reject = 1'b1;
          end
        end
        REG_TERM_SEL0, REG_TERM_SEL1, REG_TERM_SEL2: begin
          // Selectors are independent, so duplicates are allowed
          if (code_ok(i_reg_wdata)) begin
            term_sel_d[2'(i_reg_addr - REG_TERM_SEL0)] = i_reg_wdata;
          end else begin
            wr_reject = 1'b1;
          end
        end
        default: begin
          // Status registers and holes ignore writes
        end
      endcase
    end
  end

  // ==========================================================
  // Drive-state flags
  logic rotating_d, rotating_q;
  logic ready_d, ready_q;
  logic at_speed_d, at_speed_q;
  logic freq_thr_d, freq_thr_q;
  logic hard_d, hard_q;
  logic trip_d, trip_q;
  logic cmp_at_speed;
  logic cmp_above_thr;
  logic above_start;

  dso_freq_cmp u_freq_cmp (
    .i_out_freq(i_out_freq_preslip),
    .i_set_freq(i_set_freq),
    .i_band(band_q),
    .i_fwd_level(fwd_level_q),
    .i_rev_level(rev_level_q),
    .i_reverse(i_reverse),
    .o_at_speed(cmp_at_speed),
    .o_above_thr(cmp_above_thr)
  );

  always_comb begin
    above_start = (16'(i_out_freq_preslip) >= start_freq_q);
    trip_d = i_trip;
    hard_d = (|i_fault_src) || (i_accel_overcurrent_trip && i_earth_fault_cause);
    if (i_restart_seq) begin
      if (i_restarting) begin
        ready_d = 1'b1;
        rotating_d = 1'b1;
      end else if (i_start_cmd) begin
        ready_d = 1'b1;
        rotating_d = 1'b0;
      end else begin
        ready_d = i_supply_ok;
        rotating_d = 1'b0;
      end
    end else begin
      // Trip or output shutoff takes the drive out of the ready state
      rotating_d = above_start && !i_stopped && !i_dc_brake
                   && !i_trip && !i_output_shutoff_in;
      ready_d = (i_able_to_run || rotating_d) && !i_trip && !i_output_shutoff_in;
    end
    // Braking gives a stale frequency reading, so both comparisons are masked
    at_speed_d = cmp_at_speed && !i_dc_brake;
    freq_thr_d = cmp_above_thr && !i_dc_brake;
  end

  // ==========================================================
  // Terminal routing
  logic [NUM_FLAGS-1:0] flag_vec;
  logic [NUM_TERMS-1:0] conduct;
  logic [NUM_TERMS-1:0] terminal_q, terminal_d;

  always_comb begin
    flag_vec = '0;
    flag_vec[FLAG_ROTATING] = rotating_q;
    flag_vec[FLAG_AT_SPEED] = at_speed_q;
    flag_vec[FLAG_FREQ_THR] = freq_thr_q;
    flag_vec[FLAG_READY] = ready_q;
    flag_vec[FLAG_HARD_FAULT] = hard_q;
    flag_vec[FLAG_TRIP] = trip_q;
  end

  for (genvar t = 0; t < NUM_TERMS; t++) begin : g_term
    dso_term_map u_term_map (
      .i_code(term_sel_q[t]),
      .i_flags(flag_vec),
      .o_conduct(conduct[t])
    );
  end

  always_comb begin
    terminal_d = conduct;
  end

  // ==========================================================
  // Read path and write-error flag
  always_comb begin
    rdata_d = '0;
    if (i_reg_read) begin
      unique case (i_reg_addr)
        REG_START_FREQ: rdata_d = start_freq_q;
        REG_AT_SPEED_BAND: rdata_d = band_q;
        REG_FWD_DETECT: rdata_d = fwd_level_q;
        REG_REV_DETECT: rdata_d = rev_level_q;
        REG_TERM_SEL0: rdata_d = term_sel_q[0];
        REG_TERM_SEL1: rdata_d = term_sel_q[1];
        REG_TERM_SEL2: rdata_d = term_sel_q[2];
        REG_FLAGS: rdata_d = DATA_W'(flag_vec);
        REG_TERMS: rdata_d = DATA_W'(terminal_q);
        REG_WR_ERR: rdata_d = DATA_W'(wr_err_q);
        default: rdata_d = '0;
      endcase
    end
  end

  // ==========================================================
  // Write-error flag
  always_comb begin
    // Reading the error register clears it, but a new rejection wins
    wr_err_d = wr_err_q;
    if (i_reg_read && (i_reg_addr == REG_WR_ERR)) begin
      wr_err_d = 1'b0;
    end
    if (wr_reject) begin
      wr_err_d = 1'b1;
    end
  end

  // ==========================================================
  // Settings registers
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      start_freq_q <= RST_START_FREQ;
      band_q <= RST_AT_SPEED_BAND;
      fwd_level_q <= RST_FWD_DETECT;
      rev_level_q <= RST_REV_DETECT;
      term_sel_q[0] <= RST_TERM_SEL0;
      term_sel_q[1] <= RST_TERM_SEL1;
      term_sel_q[2] <= RST_TERM_SEL2;
    end else begin
      start_freq_q <= start_freq_d;
      band_q <= band_d;
      fwd_level_q <= fwd_level_d;
      rev_level_q <= rev_level_d;
      term_sel_q <= term_sel_d;
    end
  end

  // ==========================================================
  // Flag registers
  // Registered flags keep combinational glitches away from the relay
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rotating_q <= 1'b0;
      ready_q <= 1'b0;
      at_speed_q <= 1'b0;
      freq_thr_q <= 1'b0;
      hard_q <= 1'b0;
      trip_q <= 1'b0;
    end else begin
      rotating_q <= rotating_d;
      ready_q <= ready_d;
      at_speed_q <= at_speed_d;
      freq_thr_q <= freq_thr_d;
      hard_q <= hard_d;
      trip_q <= trip_d;
    end
  end

  // ==========================================================
  // Terminal register
  // Second stage: terminals trail the flag word by one cycle
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      terminal_q <= '0;
    end else begin
      terminal_q <= terminal_d;
    end
  end

  // ==========================================================
  // Read data register
  // Read data fall back to zero in every cycle without a read slot
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Write-error register
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      wr_err_q <= 1'b0;
    end else begin
      wr_err_q <= wr_err_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_terminal = terminal_q;
  assign o_flags = flag_vec;

endmodule : dso_status_out
`default_nettype wire

// ---- dso_pkg.sv ----
package dso_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned FREQ_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned NUM_FLAGS = 6;
  localparam int unsigned NUM_TERMS = 3;

  // ==========================================================
  // Register offsets (word index on the plain register port)
  localparam logic [3:0] REG_START_FREQ = 4'h0;
  localparam logic [3:0] REG_AT_SPEED_BAND = 4'h1;
  localparam logic [3:0] REG_FWD_DETECT = 4'h2;
  localparam logic [3:0] REG_REV_DETECT = 4'h3;
  localparam logic [3:0] REG_TERM_SEL0 = 4'h4;
  localparam logic [3:0] REG_TERM_SEL1 = 4'h5;
  localparam logic [3:0] REG_TERM_SEL2 = 4'h6;
  localparam logic [3:0] REG_FLAGS = 4'h8;
  localparam logic [3:0] REG_TERMS = 4'h9;
  localparam logic [3:0] REG_WR_ERR = 4'hA;

  // ==========================================================
  // Reset values; frequencies in units of 0.1 Hz
  localparam logic [15:0] RST_START_FREQ = 16'h0005;
  localparam logic [15:0] RST_AT_SPEED_BAND = 16'h000A;
  localparam logic [15:0] RST_FWD_DETECT = 16'h003C;
  localparam logic [15:0] RST_REV_DETECT = 16'h270F;
  localparam logic [15:0] RST_TERM_SEL0 = 16'h0000;
  localparam logic [15:0] RST_TERM_SEL1 = 16'h0004;
  localparam logic [15:0] RST_TERM_SEL2 = 16'h0063;

  // ==========================================================
  // Limits
  localparam logic [15:0] MAX_BAND = 16'h0064;
  localparam logic [15:0] MAX_FREQ = 16'h0FA0;
  localparam logic [15:0] REV_SAME_AS_FWD = 16'h270F;
  localparam logic [15:0] CODE_NONE = 16'h270F;
  localparam logic [15:0] CODE_NEG_OFFSET = 16'h0064;
  localparam logic [15:0] CODE_MAX = 16'h00C7;

  // ==========================================================
  // Terminal function codes, positive logic
  localparam logic [15:0] CODE_ROTATING = 16'h0000;
  localparam logic [15:0] CODE_AT_SPEED = 16'h0001;
  localparam logic [15:0] CODE_FREQ_THR = 16'h0004;
  localparam logic [15:0] CODE_READY = 16'h000B;
  localparam logic [15:0] CODE_HARD_FAULT = 16'h005B;
  localparam logic [15:0] CODE_TRIP = 16'h0063;

  // ==========================================================
  // Flag bit positions
  localparam int unsigned FLAG_ROTATING = 0;
  localparam int unsigned FLAG_AT_SPEED = 1;
  localparam int unsigned FLAG_FREQ_THR = 2;
  localparam int unsigned FLAG_READY = 3;
  localparam int unsigned FLAG_HARD_FAULT = 4;
  localparam int unsigned FLAG_TRIP = 5;

  // Hard-fault source bits of i_fault_src
  localparam int unsigned FLT_BRAKE_TRANSISTOR = 0;
  localparam int unsigned FLT_EARTH = 1;
  localparam int unsigned FLT_PHASE_LOSS = 2;
  localparam int unsigned FLT_PARAM_STORE = 3;
  localparam int unsigned FLT_BOARD = 4;
  localparam int unsigned FLT_CPU = 5;
  localparam int unsigned FLT_INRUSH = 6;
  localparam int unsigned NUM_FLT = 7;

endpackage : dso_pkg

// ---- dso_freq_cmp.sv ----
`timescale 1ns/1ps
`default_nettype none
module dso_freq_cmp
  import dso_pkg::*;
(
  input wire logic [FREQ_W-1:0] i_out_freq,
  input wire logic [FREQ_W-1:0] i_set_freq,
  input wire logic [15:0] i_band,
  input wire logic [15:0] i_fwd_level,
  input wire logic [15:0] i_rev_level,
  input wire logic i_reverse,
  output logic o_at_speed,
  output logic o_above_thr
);

  function automatic logic [FREQ_W-1:0] abs_diff(input logic [FREQ_W-1:0] a,
                                                 input logic [FREQ_W-1:0] b);
    abs_diff = (a >= b) ? (a - b) : (b - a);
  endfunction : abs_diff

  logic [FREQ_W+7:0] dev_scaled;
  logic [FREQ_W+7:0] band_scaled;
  logic [15:0] thr_level;

  // Deviation times 100 against set frequency times band percent avoids a divider
  always_comb begin
    dev_scaled = (FREQ_W+8)'(abs_diff(i_out_freq, i_set_freq)) * (FREQ_W+8)'(100);
    band_scaled = (FREQ_W+8)'(i_set_freq) * (FREQ_W+8)'(i_band[6:0]);
    o_at_speed = (dev_scaled <= band_scaled);
    if (i_reverse && (i_rev_level != REV_SAME_AS_FWD)) begin
      thr_level = i_rev_level;
    end else begin
      thr_level = i_fwd_level;
    end
    o_above_thr = (16'(i_out_freq) >= thr_level);
  end

endmodule : dso_freq_cmp
`default_nettype wire

// ---- dso_term_map.sv ----
`timescale 1ns/1ps
`default_nettype none
module dso_term_map
  import dso_pkg::*;
(
  input wire logic [15:0] i_code,
  input wire logic [NUM_FLAGS-1:0] i_flags,
  output logic o_conduct
);

  logic sel_valid;
  logic sel_neg;
  logic [15:0] base;
  logic flag;

  always_comb begin
    sel_neg = (i_code >= CODE_NEG_OFFSET) && (i_code <= CODE_MAX);
    base = sel_neg ? (i_code - CODE_NEG_OFFSET) : i_code;
    sel_valid = 1'b1;
    flag = 1'b0;
    unique case (base)
      CODE_ROTATING: flag = i_flags[FLAG_ROTATING];
      CODE_AT_SPEED: flag = i_flags[FLAG_AT_SPEED];
      CODE_FREQ_THR: flag = i_flags[FLAG_FREQ_THR];
      CODE_READY: flag = i_flags[FLAG_READY];
      CODE_HARD_FAULT: flag = i_flags[FLAG_HARD_FAULT];
      CODE_TRIP: flag = i_flags[FLAG_TRIP];
      default: sel_valid = 1'b0;
    endcase
    // An unused code or the no-function value leaves the terminal open
    if (i_code > CODE_MAX) begin
      sel_valid = 1'b0;
    end
    o_conduct = sel_valid && (flag ^ sel_neg);
  end

endmodule : dso_term_map
`default_nettype wire

// ---- dso_term_reader.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far-side controller: latches terminal levels every clock
module dso_term_reader (
  input wire logic i_clock,
  input wire logic [2:0] i_terminal,
  output logic [2:0] o_seen
);
  // One flop of latency, as a real input card would add
  always_ff @(posedge i_clock) begin
    o_seen <= i_terminal;
  end
endmodule : dso_term_reader
`default_nettype wire

// ---- dso_status_out_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module dso_status_out_chk
  import dso_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_reg_read,
  input wire logic [DATA_W-1:0] o_reg_rdata,
  input wire logic i_able_to_run,
  input wire logic i_stopped,
  input wire logic i_dc_brake,
  input wire logic i_output_shutoff_in,
  input wire logic i_trip,
  input wire logic [NUM_FLT-1:0] i_fault_src,
  input wire logic i_accel_overcurrent_trip,
  input wire logic i_earth_fault_cause,
  input wire logic i_restart_seq,
  input wire logic i_restarting,
  input wire logic i_start_cmd,
  input wire logic i_supply_ok,
  input wire logic [NUM_FLAGS-1:0] o_flags
);
  // ==========================================================
  // Flags follow their causes one cycle later
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  wire logic hard_c = (|i_fault_src) || (i_accel_overcurrent_trip && i_earth_fault_cause);
  sequence s_restart;
    i_restart_seq && i_restarting && !i_stopped && !i_dc_brake;
  endsequence
  sequence s_coast_run;
    i_restart_seq && !i_restarting && i_start_cmd;
  endsequence
  sequence s_coast_stop;
    i_restart_seq && !i_restarting && !i_start_cmd;
  endsequence
  chk_rot_stop: assert property (i_stopped && !i_restart_seq |=> !o_flags[0])
    else $error("rotating flag on while stopped");
  chk_dcb_off: assert property (i_dc_brake |=> o_flags[2:0] == 3'h0)
    else $error("flag on during dc braking");
  chk_trip_set: assert property (i_trip |=> o_flags[5])
    else $error("trip flag missing");
  chk_hard_set: assert property (hard_c |=> o_flags[4])
    else $error("hard fault flag missing");
  chk_hard_only: assert property (!hard_c |=> !o_flags[4])
    else $error("hard fault flag without cause");
  chk_ready_on: assert property (i_able_to_run && !i_trip && !i_output_shutoff_in
    && !i_restart_seq |=> o_flags[3])
    else $error("ready flag missing");
  chk_ready_off: assert property ((i_trip || i_output_shutoff_in) && !i_restart_seq
    |=> !o_flags[3])
    else $error("ready flag on at shutoff");
  chk_restart_on: assert property (s_restart |=> o_flags[3] && o_flags[0])
    else $error("restart flags wrong");
  chk_coast_run: assert property (s_coast_run |=> o_flags[3] && !o_flags[0])
    else $error("coasting flags wrong");
  chk_coast_stop: assert property (s_coast_stop |=> o_flags[3] == $past(i_supply_ok))
    else $error("ready flag ignores supply loss");
  chk_rd_idle: assert property (!i_reg_read |=> o_reg_rdata == 16'h0000)
    else $error("read data outside read slot");
endmodule : dso_status_out_chk
bind dso_status_out dso_status_out_chk u_chk (.i_clock, .i_srst, .i_reg_read, .o_reg_rdata,
  .i_able_to_run, .i_stopped, .i_dc_brake, .i_output_shutoff_in, .i_trip, .i_fault_src,
  .i_accel_overcurrent_trip, .i_earth_fault_cause, .i_restart_seq, .i_restarting,
  .i_start_cmd, .i_supply_ok, .o_flags);
`default_nettype wire

// ---- drive_status_output_logic_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module drive_status_output_logic_tb_top
  import dso_pkg::*;
;
  logic i_clock = 1'b0, i_srst = 1'b1, i_reg_write = 1'b0, i_reg_read = 1'b0;
  logic [3:0] i_reg_addr = 4'h0;
  logic [15:0] i_reg_wdata = 16'h0000, i_out_freq_preslip = 16'h0000, i_set_freq = 16'h0000;
  logic i_reverse = 1'b0, i_able_to_run = 1'b1, i_stopped = 1'b0, i_dc_brake = 1'b0;
  logic i_output_shutoff_in = 1'b0, i_trip = 1'b0, i_accel_overcurrent_trip = 1'b0;
  logic i_earth_fault_cause = 1'b0, i_restart_seq = 1'b0, i_restarting = 1'b0;
  logic i_start_cmd = 1'b0, i_supply_ok = 1'b1;
  logic [6:0] i_fault_src = 7'h00;
  logic [15:0] o_reg_rdata;
  logic [2:0] o_terminal, seen;
  logic [5:0] o_flags;
  logic [15:0] m_reg [7];
  logic [15:0] codes [14] = '{16'h0000, 16'h0001, 16'h0004, 16'h000B, 16'h005B, 16'h0063,
    16'h0064, 16'h0065, 16'h0068, 16'h006F, 16'h00BF, 16'h00C7, 16'h000D, 16'h270F};
  logic [3:0] bad_a [4] = '{4'h1, 4'h2, 4'h3, 4'h4};
  logic [15:0] bad_d [4] = '{16'h0065, 16'h0FA1, 16'h0FA1, 16'h00C8};
  int n_errors = 0, samples_checked = 0, cycles = 0;

  dso_status_out dut (.i_clock, .i_srst, .i_reg_addr, .i_reg_wdata, .i_reg_write,
    .i_reg_read, .o_reg_rdata, .i_out_freq_preslip, .i_set_freq, .i_reverse, .i_able_to_run,
    .i_stopped, .i_dc_brake, .i_output_shutoff_in, .i_trip, .i_fault_src,
    .i_accel_overcurrent_trip, .i_earth_fault_cause, .i_restart_seq, .i_restarting,
    .i_start_cmd, .i_supply_ok, .o_terminal, .o_flags);
  dso_term_reader u_reader (.i_clock(i_clock), .i_terminal(o_terminal), .o_seen(seen));

  always #2 i_clock = ~i_clock;

  // ==========================================================
  // Reporting
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic cmp_word(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t word %h exp %h", $time, g, e);
    end
  endtask : cmp_word

  task automatic cmp_bits(input logic [5:0] g, input logic [5:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t bits %b exp %b", $time, g, e);
    end
  endtask : cmp_bits

  // Cuts a hung run short; the full run needs about 3000 cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ==========================================================
  // Register port
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_write <= 1'b1;
    @(posedge i_clock);
    i_reg_write <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_clock);
    i_reg_read <= 1'b0;
    #1;
    cmp_word(o_reg_rdata, e);
  endtask : reg_rd

  task automatic set_reg(input logic [3:0] a, input logic [15:0] d);
    reg_wr(a, d);
    m_reg[a] = d;
  endtask : set_reg

  task automatic chk_defaults();
    m_reg = '{RST_START_FREQ, RST_AT_SPEED_BAND, RST_FWD_DETECT, RST_REV_DETECT,
      RST_TERM_SEL0, RST_TERM_SEL1, RST_TERM_SEL2};
    for (int k = 0; k < 7; k++) reg_rd(4'(k), m_reg[k]);
    reg_rd(4'h7, 16'h0000);
  endtask : chk_defaults

  // ==========================================================
  // Expectations
  function automatic logic pr(input int unsigned m);
    return $urandom_range(0, m - 1) == 0;
  endfunction : pr

  function automatic logic [5:0] exp_flags();
    logic rot, rdy;
    int unsigned f, s, d, lv;
    f = i_out_freq_preslip;
    s = i_set_freq;
    d = (f > s) ? f - s : s - f;
    lv = (i_reverse && m_reg[3] != REV_SAME_AS_FWD) ? m_reg[3] : m_reg[2];
    rot = i_restart_seq ? i_restarting : !i_stopped && !i_dc_brake && f >= m_reg[0]
      && !i_trip && !i_output_shutoff_in;
    rdy = i_restart_seq ? (i_restarting || i_start_cmd || i_supply_ok)
      : (i_able_to_run || rot) && !i_trip && !i_output_shutoff_in;
    return {i_trip, (|i_fault_src) || (i_accel_overcurrent_trip && i_earth_fault_cause),
      rdy, !i_dc_brake && f >= lv, !i_dc_brake && d * 100 <= s * m_reg[1], rot};
  endfunction : exp_flags

  function automatic logic exp_term(input logic [15:0] c, input logic [5:0] fl);
    logic neg;
    logic [15:0] p;
    neg = c >= CODE_NEG_OFFSET && c <= CODE_MAX;
    p = neg ? c - CODE_NEG_OFFSET : c;
    case (p)
      CODE_ROTATING: return fl[0] ^ neg;
      CODE_AT_SPEED: return fl[1] ^ neg;
      CODE_FREQ_THR: return fl[2] ^ neg;
      CODE_READY: return fl[3] ^ neg;
      CODE_HARD_FAULT: return fl[4] ^ neg;
      CODE_TRIP: return fl[5] ^ neg;
      default: return 1'b0;
    endcase
  endfunction : exp_term

  // ==========================================================
  // Random status step; restart cases keep trip, shutoff, stop and braking quiet
  task automatic step(input int unsigned n);
    logic [15:0] s;
    logic [5:0] e, t;
    logic rs;
    s = 16'($urandom_range(0, 3000));
    rs = pr(4);
    @(posedge i_clock);
    i_set_freq <= s;
    i_out_freq_preslip <= pr(2) ? 16'(s + $urandom_range(0, s / 5)) : 16'($urandom_range(0, 4000));
    i_reverse <= pr(2);
    i_able_to_run <= rs || !pr(8);
    i_stopped <= !rs && pr(8);
    i_dc_brake <= !rs && pr(8);
    i_output_shutoff_in <= !rs && pr(8);
    i_trip <= !rs && pr(8);
    i_fault_src <= pr(3) ? 7'(1 << $urandom_range(0, 6)) : 7'h00;
    i_accel_overcurrent_trip <= pr(3);
    i_earth_fault_cause <= pr(3);
    i_restart_seq <= rs;
    i_restarting <= rs && pr(2);
    i_start_cmd <= rs && pr(2);
    i_supply_ok <= !rs || pr(2);
    repeat (4) @(posedge i_clock);
    #1;
    e = exp_flags();
    t = {3'b000, exp_term(m_reg[6], e), exp_term(m_reg[5], e), exp_term(m_reg[4], e)};
    cmp_bits(o_flags & 6'h07, e & 6'h07);
    cmp_bits(o_flags & 6'h38, e & 6'h38);
    cmp_bits({3'b000, seen}, t);
    reg_rd(REG_FLAGS, 16'(e));
    reg_rd(REG_TERMS, 16'(t));
  endtask : step

  initial begin : main
    void'($urandom(99));
    repeat (4) @(posedge i_clock);
    i_srst <= 1'b0;
    chk_defaults();
    for (int i = 0; i < 8; i++) step(i);
    for (int i = 0; i < 4; i++) begin
      reg_wr(bad_a[i], bad_d[i]);
      reg_rd(bad_a[i], m_reg[bad_a[i]]);
      reg_rd(REG_WR_ERR, 16'h0001);
      reg_rd(REG_WR_ERR, 16'h0000);
    end
    for (int i = 0; i < 56; i++) begin
      set_reg(REG_START_FREQ, 16'($urandom_range(0, 50)));
      set_reg(REG_AT_SPEED_BAND, pr(8) ? MAX_BAND : 16'($urandom_range(0, 100)));
      set_reg(REG_FWD_DETECT, pr(8) ? MAX_FREQ : 16'($urandom_range(0, 4000)));
      set_reg(REG_REV_DETECT, pr(2) ? REV_SAME_AS_FWD : 16'($urandom_range(0, 4000)));
      for (int k = 0; k < 3; k++) set_reg(4'(4 + k), codes[(i + 5 * k) % 14]);
      repeat (4) step(i);
    end
    // Second reset at the end of the run must restore every default
    @(posedge i_clock);
    i_srst <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1;
    cmp_bits(o_flags, 6'h00);
    cmp_bits({3'b000, o_terminal}, 6'h00);
    @(posedge i_clock);
    i_srst <= 1'b0;
    chk_defaults();
    wrap_up();
  end
endmodule : drive_status_output_logic_tb_top
`default_nettype wire
